// >>> splitter_consts.vh
`ifndef SPLITTER_CONSTS_VH
`define SPLITTER_CONSTS_VH

// Largest command in bytes and the address bits below a burst boundary.
`define BURST_LIMIT_BYTES 6'h20
`define BURST_OFS_BITS 5
// Highest row count that still allows a two-dimensional request to merge.
`define MERGE_ROW_LIMIT 16'h03ff
// Entries of the destination register set.
`define DST_DEPTH 3'h4
`define DST_PTR_BITS 2
// Address style encoding on the request port.
`define ADDRESS_STEP_UP 1'b0

// Register byte offsets.
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_DONE_COUNT 4'h8

// Control fields and reset value.
`define CTRL_ENABLE 0
`define CTRL_MERGE 1
`define CTRL_RESET 2'h3

// Status fields.
`define STAT_SRC_BUSY 0
`define STAT_DST_BUSY 1
`define STAT_DCOUNT_LO 4

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> dest_entry_ram.v
`timescale 1ns/10ps
// Small register-file memory with a registered read port.
module dest_entry_ram #(
  parameter WIDTH = 85,
  parameter ABITS = 2
) (
  input wire aclk,
  input wire wr_en,
  input wire [ABITS-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [ABITS-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // dest_entry_ram

// >>> transfer_command_splitter.v
// Summary of operation
// - Carry out every accepted move_job end to end.
// - Read and write sides issue efficiently sized commands.
// - Commands as large as limit and row allow.
// - No command exceeds burst_limit_bytes.
// - First linear command aligns the following ones.
// - Rows longer than the burst split into bursts.
// - Rows serviced in turn until row_count done.
// - Merge only small power-of-two rows with pitch equal.
// - Merge also needs address_step_up; else row-by-row.
// - Row count limit for merging is inclusive.
// - Merge decided separately for read and write.
// - Reads of next job overlap earlier writes.
// - Jobs in flight capped by destination entries.
// - Accept job only when both sets have room.
// - Writes start once enough read data landed.
// - Report completion of each job to requester.
`timescale 1ns/10ps
`include "splitter_consts.vh"
module transfer_command_splitter (
  input wire aclk,
  input wire aresetn,
  input wire job_valid,
  output wire job_ready,
  input wire [31:0] job_source_pointer,
  input wire [31:0] job_dest_pointer,
  input wire [15:0] job_row_bytes,
  input wire [15:0] job_row_count,
  input wire [15:0] job_src_row_pitch,
  input wire [15:0] job_dst_row_pitch,
  input wire job_src_address_style,
  input wire job_dst_address_style,
  input wire [3:0] job_tag,
  output wire rd_cmd_valid,
  input wire rd_cmd_ready,
  output wire [31:0] rd_cmd_addr,
  output wire [5:0] rd_cmd_bytes,
  input wire rd_land_valid,
  input wire [5:0] rd_land_bytes,
  output wire wr_cmd_valid,
  input wire wr_cmd_ready,
  output wire [31:0] wr_cmd_addr,
  output wire [5:0] wr_cmd_bytes,
  output reg cpl_valid,
  output reg [3:0] cpl_tag,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam W_IDLE = 2'h0;
  localparam W_WAIT = 2'h1;
  localparam W_RUN = 2'h2;
  localparam ENTRY_W = 85;

  // Size of the next command: up to the next burst boundary, capped by what is left.
  function [5:0] chunk_of;
    input [31:0] addr;
    input [15:0] left;
    reg [5:0] room;
    begin
      room = `BURST_LIMIT_BYTES - {1'b0, addr[`BURST_OFS_BITS-1:0]};
      chunk_of = ({10'h000, room} < left) ? room : left[5:0];
    end
  endfunction

  function mergeable;
    input [15:0] rb;
    input [15:0] rc;
    input [15:0] pitch;
    input style;
    input allow;
    begin
      mergeable = allow && (rb != 16'h0000)
        && (rb <= {10'h000, `BURST_LIMIT_BYTES})
        && ((rb & (rb - 16'h0001)) == 16'h0000)
        && (pitch == rb)
        && (rc <= `MERGE_ROW_LIMIT)
        && (style == `ADDRESS_STEP_UP);
    end
  endfunction

  reg [1:0] control;
  reg [15:0] done_count;

  // Source active set.
  reg s_act;
  reg [31:0] s_addr;
  reg [31:0] s_base;
  reg [15:0] s_left;
  reg [15:0] s_rows;
  reg [15:0] s_rb;
  reg [15:0] s_pitch;

  // Destination register set bookkeeping.
  reg [`DST_PTR_BITS-1:0] d_head;
  reg [`DST_PTR_BITS-1:0] d_tail;
  reg [2:0] d_count;

  // Write side working copy of the head entry.
  reg [1:0] w_state;
  reg [31:0] w_addr;
  reg [31:0] w_base;
  reg [15:0] w_left;
  reg [15:0] w_rows;
  reg [15:0] w_rb;
  reg [15:0] w_pitch;
  reg [3:0] w_tag;
  reg [15:0] credit;

  wire [ENTRY_W-1:0] head_entry;
  wire src_merge;
  wire dst_merge;
  wire job_take;
  wire rd_take;
  wire wr_take;
  wire pop;
  wire [5:0] rd_chunk;
  wire [5:0] wr_chunk;
  wire [31:0] job_span;
  wire [15:0] e_rb;
  wire [15:0] e_rc;
  wire [15:0] e_pitch;
  wire e_merge;
  wire [31:0] e_span;

  // Each side decides independently whether it can run as one linear stream.
  assign src_merge = mergeable(job_row_bytes, job_row_count, job_src_row_pitch,
    job_src_address_style, control[`CTRL_MERGE]);
  assign dst_merge = mergeable(job_row_bytes, job_row_count, job_dst_row_pitch,
    job_dst_address_style, control[`CTRL_MERGE]);
  assign job_span = job_row_bytes * job_row_count;

  // A new job waits for the source set to drain and a free destination entry,
  // but not for the writes of earlier jobs.
  assign job_ready = control[`CTRL_ENABLE] && !s_act
    && (d_count != `DST_DEPTH);
  assign job_take = job_valid && job_ready;

  assign rd_chunk = chunk_of(s_addr, s_left);
  assign rd_cmd_valid = s_act;
  assign rd_cmd_addr = s_addr;
  assign rd_cmd_bytes = rd_chunk;
  assign rd_take = rd_cmd_valid && rd_cmd_ready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_act <= 1'b0;
      s_addr <= 32'h00000000;
      s_base <= 32'h00000000;
      s_left <= 16'h0000;
      s_rows <= 16'h0000;
      s_rb <= 16'h0000;
      s_pitch <= 16'h0000;
    end else if (job_take) begin
      // An empty job issues no reads; its entry completes on the write side.
      s_act <= (job_row_bytes != 16'h0000) && (job_row_count != 16'h0000);
      s_addr <= job_source_pointer;
      s_base <= job_source_pointer;
      s_rb <= job_row_bytes;
      s_pitch <= job_src_row_pitch;
      if (src_merge) begin
        s_left <= job_span[15:0];
        s_rows <= 16'h0001;
      end else begin
        s_left <= job_row_bytes;
        s_rows <= job_row_count;
      end
    end else if (rd_take) begin
      if ({10'h000, rd_chunk} == s_left) begin
        if (s_rows == 16'h0001) begin
          s_act <= 1'b0;
        end else begin
          s_rows <= s_rows - 16'h0001;
          s_base <= s_base + {{16{s_pitch[15]}}, s_pitch};
          s_addr <= s_base + {{16{s_pitch[15]}}, s_pitch};
          s_left <= s_rb;
        end
      end else begin
        s_addr <= s_addr + {26'h0000000, rd_chunk};
        s_left <= s_left - {10'h000, rd_chunk};
      end
    end
  end

  dest_entry_ram #(
    .WIDTH(ENTRY_W),
    .ABITS(`DST_PTR_BITS)
  ) dst_set (
    .aclk(aclk),
    .wr_en(job_take),
    .wr_addr(d_tail),
    .wr_data({job_tag, dst_merge, job_dst_row_pitch, job_row_count, job_row_bytes,
      job_dest_pointer}),
    .rd_addr(d_head),
    .rd_data(head_entry)
  );

  assign e_rb = head_entry[47:32];
  assign e_rc = head_entry[63:48];
  assign e_pitch = head_entry[79:64];
  assign e_merge = head_entry[80];
  assign e_span = e_rb * e_rc;

  // Writes draw on bytes already landed in the data FIFO.
  assign wr_chunk = chunk_of(w_addr, w_left);
  assign wr_cmd_valid = (w_state == W_RUN) && (w_left != 16'h0000)
    && (credit >= {10'h000, wr_chunk});
  assign wr_cmd_addr = w_addr;
  assign wr_cmd_bytes = wr_chunk;
  assign wr_take = wr_cmd_valid && wr_cmd_ready;
  assign pop = (w_state == W_RUN) && ((w_left == 16'h0000)
    || (wr_take && ({10'h000, wr_chunk} == w_left) && (w_rows == 16'h0001)));

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_state <= W_IDLE;
      w_addr <= 32'h00000000;
      w_base <= 32'h00000000;
      w_left <= 16'h0000;
      w_rows <= 16'h0000;
      w_rb <= 16'h0000;
      w_pitch <= 16'h0000;
      w_tag <= 4'h0;
      cpl_valid <= 1'b0;
      cpl_tag <= 4'h0;
    end else begin
      cpl_valid <= 1'b0;
      case (w_state)
        W_IDLE: begin
          // One cycle lets the registered read settle on the new head.
          if (d_count != 3'h0) begin
            w_state <= W_WAIT;
          end
        end
        W_WAIT: begin
          w_state <= W_RUN;
          w_addr <= head_entry[31:0];
          w_base <= head_entry[31:0];
          w_rb <= e_rb;
          w_pitch <= e_pitch;
          w_tag <= head_entry[84:81];
          if (e_rc == 16'h0000) begin
            w_left <= 16'h0000;
            w_rows <= 16'h0001;
          end else if (e_merge) begin
            w_left <= e_span[15:0];
            w_rows <= 16'h0001;
          end else begin
            w_left <= e_rb;
            w_rows <= e_rc;
          end
        end
        W_RUN: begin
          if (pop) begin
            w_state <= W_IDLE;
            w_left <= 16'h0000;
            cpl_valid <= 1'b1;
            cpl_tag <= w_tag;
          end else if (wr_take) begin
            if ({10'h000, wr_chunk} == w_left) begin
              w_rows <= w_rows - 16'h0001;
              w_base <= w_base + {{16{w_pitch[15]}}, w_pitch};
              w_addr <= w_base + {{16{w_pitch[15]}}, w_pitch};
              w_left <= w_rb;
            end else begin
              w_addr <= w_addr + {26'h0000000, wr_chunk};
              w_left <= w_left - {10'h000, wr_chunk};
            end
          end
        end
        default: begin
          w_state <= W_IDLE;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      d_head <= {`DST_PTR_BITS{1'b0}};
      d_tail <= {`DST_PTR_BITS{1'b0}};
      d_count <= 3'h0;
      credit <= 16'h0000;
      done_count <= 16'h0000;
    end else begin
      if (job_take) begin
        d_tail <= d_tail + 2'h1;
      end
      if (pop) begin
        d_head <= d_head + 2'h1;
        done_count <= done_count + 16'h0001;
      end
      if (job_take && !pop) begin
        d_count <= d_count + 3'h1;
      end else if (pop && !job_take) begin
        d_count <= d_count - 3'h1;
      end
      // Landed bytes and spent bytes may meet in one cycle; both count.
      credit <= credit + (rd_land_valid ? {10'h000, rd_land_bytes} : 16'h0000)
        - (wr_take ? {10'h000, wr_chunk} : 16'h0000);
    end
  end

  // AXI4-Lite slave. Address and data are latched separately and may come
  // in either order; one write and one read are handled at a time.
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go;
  wire [31:0] status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign status_word = {25'h0000000, d_count, 2'h0, (w_state != W_IDLE), s_act};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      control <= `CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (aw_addr == `REG_CONTROL) begin
          if (w_strb[0]) begin
            control <= w_data[1:0];
          end
        end else if (aw_addr == `REG_STATUS || aw_addr == `REG_DONE_COUNT) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      if (s_axi_araddr == `REG_CONTROL) begin
        s_axi_rdata <= {30'h00000000, control};
      end else if (s_axi_araddr == `REG_STATUS) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr == `REG_DONE_COUNT) begin
        s_axi_rdata <= {16'h0000, done_count};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // transfer_command_splitter

// >>> splitter_props.sv
`timescale 1ns/10ps
`include "splitter_consts.vh"
module splitter_props (
  input logic aclk,
  input logic aresetn,
  input logic job_valid,
  input logic job_ready,
  input logic [15:0] job_row_bytes,
  input logic [15:0] job_row_count,
  input logic rd_cmd_valid,
  input logic rd_cmd_ready,
  input logic [31:0] rd_cmd_addr,
  input logic [5:0] rd_cmd_bytes,
  input logic rd_land_valid,
  input logic [5:0] rd_land_bytes,
  input logic wr_cmd_valid,
  input logic wr_cmd_ready,
  input logic [31:0] wr_cmd_addr,
  input logic [5:0] wr_cmd_bytes,
  input logic cpl_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [2:0] infl;
  logic [15:0] credit;
  wire take = job_valid && job_ready;
  wire wr_hs = wr_cmd_valid && wr_cmd_ready;
  // Credit mirrors landed minus written bytes, so a write may never outrun its data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      infl <= 3'h0;
      credit <= 16'h0;
    end else begin
      infl <= infl + {2'h0, take} - {2'h0, cpl_valid};
      credit <= credit + (rd_land_valid ? {10'h0, rd_land_bytes} : 16'h0)
        - (wr_hs ? {10'h0, wr_cmd_bytes} : 16'h0);
    end
  end
  sequence job_take;
    take && job_row_bytes != 16'h0 && job_row_count != 16'h0;
  endsequence
  sequence rd_start;
    rd_cmd_valid;
  endsequence
  job_start_a: assert property (job_take |=> rd_start)
    else $error("read command did not follow an accepted job");
  rd_limit_a: assert property (rd_cmd_valid |-> rd_cmd_bytes != 6'h0
    && rd_cmd_bytes <= `BURST_LIMIT_BYTES) else $error("read command size out of range");
  wr_limit_a: assert property (wr_cmd_valid |-> wr_cmd_bytes != 6'h0
    && wr_cmd_bytes <= `BURST_LIMIT_BYTES) else $error("write command size out of range");
  rd_align_a: assert property (rd_cmd_valid |->
    {2'h0, rd_cmd_addr[4:0]} + {1'h0, rd_cmd_bytes} <= 7'h20)
    else $error("read command crosses a burst boundary");
  wr_align_a: assert property (wr_cmd_valid |->
    {2'h0, wr_cmd_addr[4:0]} + {1'h0, wr_cmd_bytes} <= 7'h20)
    else $error("write command crosses a burst boundary");
  rd_hold_a: assert property (rd_cmd_valid && !rd_cmd_ready |=> rd_cmd_valid
    && $stable(rd_cmd_addr) && $stable(rd_cmd_bytes)) else $error("read command dropped");
  wr_hold_a: assert property (wr_cmd_valid && !wr_cmd_ready |=> wr_cmd_valid
    && $stable(wr_cmd_addr) && $stable(wr_cmd_bytes)) else $error("write command dropped");
  source_busy_a: assert property (rd_cmd_valid |-> !job_ready)
    else $error("job accepted while source set busy");
  dest_cap_a: assert property (infl == `DST_DEPTH && !cpl_valid |-> !job_ready)
    else $error("job accepted with destination entries full");
  write_credit_a: assert property (wr_hs |-> credit >= {10'h0, wr_cmd_bytes})
    else $error("write command issued without landed data");
  cpl_after_a: assert property (cpl_valid |-> $past(wr_hs))
    else $error("completion without a final write command");
endmodule // splitter_props
bind transfer_command_splitter splitter_props props (.*);

// >>> far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
  input logic aclk,
  input logic aresetn,
  input logic rd_cmd_valid,
  output logic rd_cmd_ready,
  input logic [5:0] rd_cmd_bytes,
  output logic rd_land_valid,
  output logic [5:0] rd_land_bytes,
  output logic wr_cmd_ready
);
  int q[$];
  // One source endpoint returns each read as one late beat; random stalls everywhere.
  // Every output has this single driver, so reset values come from the clocked branch.
  always @(posedge aclk) begin
    if (!aresetn) begin
      q.delete();
      rd_land_valid <= 1'b0;
      rd_land_bytes <= 6'h0;
      rd_cmd_ready <= 1'b0;
      wr_cmd_ready <= 1'b0;
    end else begin
      if (rd_cmd_valid && rd_cmd_ready) q.push_back(rd_cmd_bytes);
      rd_land_valid <= 1'b0;
      rd_land_bytes <= ~rd_land_bytes;
      if (q.size() != 0 && $urandom_range(1) == 1) begin
        rd_land_valid <= 1'b1;
        rd_land_bytes <= 6'(q.pop_front());
      end
      rd_cmd_ready <= $urandom_range(3) != 0;
      wr_cmd_ready <= $urandom_range(3) != 0;
    end
  end
endmodule // far_side_model

// >>> tb.sv
`timescale 1ns/10ps
`include "splitter_consts.vh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic job_valid = 1'b0;
  logic job_src_address_style = 1'b0;
  logic job_dst_address_style = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] job_source_pointer = 32'h0, job_dest_pointer = 32'h0, s_axi_wdata = 32'h0;
  logic [15:0] job_row_bytes = 16'h0, job_row_count = 16'h0;
  logic [15:0] job_src_row_pitch = 16'h0, job_dst_row_pitch = 16'h0;
  logic [3:0] job_tag = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic job_ready, rd_cmd_valid, rd_cmd_ready, rd_land_valid, wr_cmd_valid, wr_cmd_ready;
  logic cpl_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] rd_cmd_addr, wr_cmd_addr, s_axi_rdata;
  logic [5:0] rd_cmd_bytes, rd_land_bytes, wr_cmd_bytes;
  logic [3:0] cpl_tag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [37:0] rq[$], wq[$];
  logic [3:0] cq[$];
  logic [3:0] tg = 4'h0;
  int mismatches = 0, check_count = 0, cyc = 0, nj = 0, rb, rc;
  bit mrg = 1'b1;
  transfer_command_splitter dut (.*);
  far_side_model far (.*);
  always #2.5 aclk = ~aclk;
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [37:0] e, input logic [37:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task gen(input bit w, input logic [31:0] a, input int rb, rc, p, st);
    int n, o, r, t;
    logic [31:0] x;
    t = rb;
    r = rc;
    if (mrg && st == 0 && p == rb && rb <= 32 && (rb & (rb - 1)) == 0 && rc <= 1023) begin
      t = rb * rc;
      r = 1;
    end
    for (int i = 0; i < r; i++) begin
      x = a + i * p;
      o = t;
      while (o > 0) begin
        n = 32 - x[4:0];
        if (n > o) n = o;
        if (w) wq.push_back({x, 6'(n)});
        else rq.push_back({x, 6'(n)});
        x += n;
        o -= n;
      end
    end
  endtask
  task job(input logic [31:0] s, d, input int rb, rc, sp, dp, ss);
    gen(0, s, rb, rc, sp, ss & 1);
    gen(1, d, rb, rc, dp, ss >> 1);
    cq.push_back(tg);
    @(posedge aclk);
    job_source_pointer <= s;
    job_dest_pointer <= d;
    job_row_bytes <= 16'(rb);
    job_row_count <= 16'(rc);
    job_src_row_pitch <= 16'(sp);
    job_dst_row_pitch <= 16'(dp);
    job_src_address_style <= ss[0];
    job_dst_address_style <= ss[1];
    job_tag <= tg;
    job_valid <= 1'b1;
    tg++;
    nj++;
    @(posedge aclk);
    while (!job_ready) @(posedge aclk);
    job_valid <= 1'b0;
  endtask
  task drain(input string n);
    while (rq.size() + wq.size() + cq.size() != 0) @(posedge aclk);
    $display("test %s done", n);
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", {36'h0, r}, {36'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    chk("rdata", {6'h0, d}, {6'h0, s_axi_rdata});
    chk("rresp", {36'h0, r}, {36'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      end_sim;
    end
    if (aresetn && rd_cmd_valid && rd_cmd_ready)
      chk("rd_cmd", rq.pop_front(), {rd_cmd_addr, rd_cmd_bytes});
    if (aresetn && wr_cmd_valid && wr_cmd_ready)
      chk("wr_cmd", wq.pop_front(), {wr_cmd_addr, wr_cmd_bytes});
    if (aresetn && cpl_valid)
      chk("cpl_tag", {34'h0, cq.pop_front()}, {34'h0, cpl_tag});
  end
  initial begin
    void'($urandom(19983));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`REG_CONTROL, 32'h3, `RESP_OKAY);
    axr(`REG_STATUS, 32'h0, `RESP_OKAY);
    axr(4'hc, 32'h0, `RESP_SLVERR);
    axw(4'hc, 32'h0, `RESP_SLVERR);
    axw(`REG_STATUS, 32'hffffffff, `RESP_OKAY);
    axr(`REG_STATUS, 32'h0, `RESP_OKAY);
    axr(`REG_CONTROL, 32'h3, `RESP_OKAY);
    axw(`REG_CONTROL, 32'h0, `RESP_OKAY);
    chk("job_ready", 38'h0, {37'h0, job_ready});
    axw(`REG_CONTROL, 32'h3, `RESP_OKAY);
    $display("test registers done");
    job(32'd64, 32'd191, 8, 8, 8, 10, 0);
    job(32'd31, 32'd513, 64, 1, 64, 64, 0);
    job(32'h100, 32'h2000, 8, 1023, 8, 8, 0);
    job(32'h100, 32'h9000, 8, 1024, 8, 8, 0);
    job(32'h5, 32'h9, 3, 4, 3, 3, 0);
    job(32'h0, 32'h0, 16, 3, 16, 16, 3);
    job(32'h40, 32'h80, 64, 2, 64, 64, 0);
    job(32'h4000, 32'h5000, 12, 3, -20, 40, 0);
    drain("fragmentation");
    // Back-to-back small jobs keep several destination entries occupied.
    repeat (12) begin
      rb = 1 + $urandom_range(39);
      rc = 1 + $urandom_range(3);
      job($urandom, $urandom, rb, rc, rb + $urandom_range(1) * 4, rb, $urandom_range(3));
    end
    drain("pipelining");
    axw(`REG_CONTROL, 32'h1, `RESP_OKAY);
    mrg = 1'b0;
    job(32'd64, 32'd191, 8, 8, 8, 10, 0);
    drain("merge off");
    axr(`REG_DONE_COUNT, 32'(nj), `RESP_OKAY);
    end_sim;
  end
endmodule // tb
